// ==== gpcm_consts.svh ====
// register offsets, field positions and reset values of the spare-bit / clkout-select bank
`ifndef GPCM_CONSTS_SVH
`define GPCM_CONSTS_SVH

`define GPCM_ADDR_W 8
`define GPCM_DATA_W 8
`define GPCM_OFS_SPARE 8'h11
`define GPCM_OFS_CLK_SEL 8'h12
`define GPCM_SPARE_MSB 6
`define GPCM_SEL_MSB 3
`define GPCM_SEL_EVENT 3
`define GPCM_SEL_ALARM 2
`define GPCM_SEL_COUNTDOWN 1
`define GPCM_SEL_TICK 0
`define GPCM_SPARE_RESET 7'h00
`define GPCM_SEL_RESET 4'h0
`define GPCM_SEL_ALL 4'hf
`define GPCM_RDATA_RESET 8'h00

`endif

// ==== gpcm_pkg.sv ====
// types shared by the spare-bit / clkout-select bank
`include "gpcm_consts.svh"

package gpcm_pkg;
  typedef logic [`GPCM_DATA_W-1:0] gpcm_byte_t;
  typedef logic [`GPCM_ADDR_W-1:0] gpcm_addr_t;
  typedef logic [`GPCM_SPARE_MSB:0] gpcm_spare_t;
  typedef logic [`GPCM_SEL_MSB:0] gpcm_sel_t;
endpackage

// ==== gpcm_trig_if.sv ====
// select mask, interrupt levels and clock output request between bank and trigger
`timescale 1ns/1ps
`include "gpcm_consts.svh"

interface gpcm_trig_if;
  logic [`GPCM_SEL_MSB:0] select;
  logic [`GPCM_SEL_MSB:0] irq;
  logic req;
  modport bank (output select, output irq, input req);
  modport trig (input select, input irq, output req);
endinterface

// ==== gpcm_trigger.sv ====
// combines selected interrupt levels into the registered clock output request
`timescale 1ns/1ps
`include "gpcm_consts.svh"

module gpcm_trigger
  import gpcm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  gpcm_trig_if.trig tif
);

  logic req_q;
  logic req_d;

  // ----------------------------------------
  // or of every selected source
  // ----------------------------------------
  always_comb begin
    req_d = |(tif.select & tif.irq);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_d;
    end
  end

  assign tif.req = req_q;

endmodule // gpcm_trigger

// ==== gpcm_regs.sv ====
// spare storage bits and clock output interrupt select bank
// Behaviour
// - seven spare bits at positions 6:0, readable and writable, affecting nothing else
// - unimplemented bits read zero and ignore writes
// - reads always answered; writes dropped while password protection active
// - select register clears to zero at power-on
// - a select bit at one picks its interrupt as clock output trigger
// - any combination of select bits may be set together
// - select bit 3 picks the event interrupt
// - bit 2 alarm, bit 1 countdown, bit 0 tick update
`timescale 1ns/1ps
`include "gpcm_consts.svh"

module gpcm_regs
  import gpcm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire gpcm_addr_t reg_addr,
  input wire gpcm_byte_t reg_wdata,
  input wire logic write_protect,
  input wire logic event_irq_signal,
  input wire logic alarm_irq_signal,
  input wire logic countdown_irq_signal,
  input wire logic tick_update_irq_signal,
  output gpcm_byte_t reg_rdata,
  output logic reg_rd_valid,
  output gpcm_spare_t spare_storage_bit,
  output logic clkout_on_event_select,
  output logic clkout_on_alarm_select,
  output logic clkout_on_countdown_select,
  output logic clkout_on_tick_update_select,
  output logic clkout_enable_req
);

  gpcm_spare_t spare_q;
  gpcm_spare_t spare_d;
  gpcm_sel_t sel_q;
  gpcm_sel_t sel_d;
  gpcm_byte_t rdata_q;
  gpcm_byte_t rdata_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic wr_ok;

  gpcm_trig_if tif ();

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_comb begin
    wr_ok = reg_wr_en && !write_protect;
    spare_d = spare_q;
    sel_d = sel_q;
    if (wr_ok && reg_addr == `GPCM_OFS_SPARE) begin
      spare_d = reg_wdata[`GPCM_SPARE_MSB:0];
    end
    if (wr_ok && reg_addr == `GPCM_OFS_CLK_SEL) begin
      sel_d = reg_wdata[`GPCM_SEL_MSB:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      spare_q <= `GPCM_SPARE_RESET;
      sel_q <= `GPCM_SEL_RESET;
    end else begin
      spare_q <= spare_d;
      sel_q <= sel_d;
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_comb begin
    rd_valid_d = reg_rd_en;
    rdata_d = `GPCM_RDATA_RESET;
    if (reg_rd_en) begin
      case (reg_addr)
        `GPCM_OFS_SPARE: begin
          rdata_d = {1'b0, spare_q};
        end
        `GPCM_OFS_CLK_SEL: begin
          rdata_d = {4'h0, sel_q};
        end
        default: begin
          rdata_d = `GPCM_RDATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= `GPCM_RDATA_RESET;
      rd_valid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // ----------------------------------------
  // trigger sources
  // ----------------------------------------
  assign tif.select = sel_q;
  assign tif.irq[`GPCM_SEL_EVENT] = event_irq_signal;
  assign tif.irq[`GPCM_SEL_ALARM] = alarm_irq_signal;
  assign tif.irq[`GPCM_SEL_COUNTDOWN] = countdown_irq_signal;
  assign tif.irq[`GPCM_SEL_TICK] = tick_update_irq_signal;

  gpcm_trigger u_trigger (
    .clk(clk),
    .reset_n(reset_n),
    .tif(tif.trig)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_q;
  assign reg_rd_valid = rd_valid_q;
  assign spare_storage_bit = spare_q;
  assign clkout_on_event_select = sel_q[`GPCM_SEL_EVENT];
  assign clkout_on_alarm_select = sel_q[`GPCM_SEL_ALARM];
  assign clkout_on_countdown_select = sel_q[`GPCM_SEL_COUNTDOWN];
  assign clkout_on_tick_update_select = sel_q[`GPCM_SEL_TICK];
  assign clkout_enable_req = tif.req;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_spare_write: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr_en && !write_protect && reg_addr == `GPCM_OFS_SPARE
    |=> spare_storage_bit == $past(reg_wdata[`GPCM_SPARE_MSB:0]))
    else $error("spare bits did not take the written value");

  a_sel_write: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr_en && !write_protect && reg_addr == `GPCM_OFS_CLK_SEL
    |=> sel_q == $past(reg_wdata[`GPCM_SEL_MSB:0]))
    else $error("select register did not take the written value");

  a_spare_isolated: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr_en && reg_addr == `GPCM_OFS_SPARE |=> $stable(sel_q))
    else $error("spare bit write changed the select register");

  a_unmapped_ignored: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr_en && reg_addr != `GPCM_OFS_SPARE && reg_addr != `GPCM_OFS_CLK_SEL
    |=> $stable(spare_q) && $stable(sel_q))
    else $error("write to an unmapped address changed a register");

  a_protect_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr_en && write_protect |=> $stable(spare_q) && $stable(sel_q))
    else $error("protected write changed a register");

  a_read_answer: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");

  a_protect_read: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd_en && write_protect |=> reg_rd_valid)
    else $error("read not answered under write protection");

  a_read_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !reg_rd_en |=> !reg_rd_valid && reg_rdata == `GPCM_RDATA_RESET)
    else $error("read answer shown without a read");

  a_spare_readback: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd_en && reg_addr == `GPCM_OFS_SPARE
    |=> reg_rdata == {1'b0, $past(spare_q)})
    else $error("spare bit readback wrong");

  a_sel_readback: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd_en && reg_addr == `GPCM_OFS_CLK_SEL
    |=> reg_rdata == {4'h0, $past(sel_q)})
    else $error("select readback wrong");

  a_req_or: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 clkout_enable_req == |($past(sel_q) & $past(tif.irq)))
    else $error("clock output request not the or of selected sources");

  a_event_trigger: assert property (@(posedge clk) disable iff (!reset_n)
    sel_q[`GPCM_SEL_EVENT] && event_irq_signal |=> clkout_enable_req)
    else $error("selected event interrupt did not request clock output");

  a_alarm_trigger: assert property (@(posedge clk) disable iff (!reset_n)
    sel_q[`GPCM_SEL_ALARM] && alarm_irq_signal |=> clkout_enable_req)
    else $error("selected alarm interrupt did not request clock output");

  a_countdown_trigger: assert property (@(posedge clk) disable iff (!reset_n)
    sel_q[`GPCM_SEL_COUNTDOWN] && countdown_irq_signal |=> clkout_enable_req)
    else $error("selected countdown interrupt did not request clock output");

  a_tick_trigger: assert property (@(posedge clk) disable iff (!reset_n)
    sel_q[`GPCM_SEL_TICK] && tick_update_irq_signal |=> clkout_enable_req)
    else $error("selected tick update interrupt did not request clock output");

  a_unselected_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    sel_q == `GPCM_SEL_RESET |=> !clkout_enable_req)
    else $error("request raised with nothing selected");

  a_masked_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (sel_q & {event_irq_signal, alarm_irq_signal,
        countdown_irq_signal, tick_update_irq_signal}) == `GPCM_SEL_RESET
    |=> !clkout_enable_req)
    else $error("request raised by an unselected interrupt");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_spare_write: cover property (@(posedge clk) disable iff (!reset_n)
    reg_wr_en && !write_protect && reg_addr == `GPCM_OFS_SPARE);

  c_protected_write: cover property (@(posedge clk) disable iff (!reset_n)
    reg_wr_en && write_protect && reg_addr == `GPCM_OFS_CLK_SEL);

  c_multi_select: cover property (@(posedge clk) disable iff (!reset_n)
    sel_q == `GPCM_SEL_ALL ##1 clkout_enable_req);

  c_event_request: cover property (@(posedge clk) disable iff (!reset_n)
    sel_q[`GPCM_SEL_EVENT] && event_irq_signal ##1 clkout_enable_req);

  c_unmapped_read: cover property (@(posedge clk) disable iff (!reset_n)
    reg_rd_en && reg_addr != `GPCM_OFS_SPARE && reg_addr != `GPCM_OFS_CLK_SEL);

endmodule // gpcm_regs

// ==== gpcm_host_model.sv ====
// serial bus host model driving the register port of the bank
`timescale 1ns/1ps
module gpcm_host_model
  import gpcm_pkg::*;
(
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output gpcm_addr_t addr,
  output gpcm_byte_t wdata,
  input wire gpcm_byte_t rdata,
  input wire logic rd_valid
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // one write strobe, data scrambled once released
  task automatic wr(input gpcm_addr_t a, input gpcm_byte_t d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    wdata = ~d;
  endtask
  // one read strobe, answer taken one cycle later
  task automatic rd(input gpcm_addr_t a, output gpcm_byte_t d, output logic v);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~a;
    d = rdata;
    v = rd_valid;
  endtask
endmodule // gpcm_host_model

// ==== gpcm_tb.sv ====
// self-checking bench of the spare-bit / clkout-select bank
`timescale 1ns/1ps
module tb
  import gpcm_pkg::*;
;
  typedef struct {gpcm_addr_t a; gpcm_byte_t w; gpcm_byte_t e;} gpcm_row_s;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic write_protect = 1'b0;
  logic [3:0] irq = 4'h0;
  logic wr_en, rd_en, rd_valid, req, ev, al, cd, tk, v;
  gpcm_addr_t addr;
  gpcm_byte_t wdata, rdata, d;
  gpcm_spare_t spare;
  int failures = 0;
  int n_tests = 0;
  gpcm_row_s rows [6] = '{'{8'h11, 8'h7f, 8'h7f}, '{8'h11, 8'hff, 8'h7f},
    '{8'h12, 8'hf5, 8'h05}, '{8'h12, 8'h0a, 8'h0a}, '{8'h12, 8'h0f, 8'h0f},
    '{8'h11, 8'h2a, 8'h2a}};
  always #5 clk = ~clk;
  gpcm_regs DUT (.clk(clk), .reset_n(reset_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .write_protect(write_protect),
    .event_irq_signal(irq[3]), .alarm_irq_signal(irq[2]), .countdown_irq_signal(irq[1]),
    .tick_update_irq_signal(irq[0]), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
    .spare_storage_bit(spare), .clkout_on_event_select(ev), .clkout_on_alarm_select(al),
    .clkout_on_countdown_select(cd), .clkout_on_tick_update_select(tk),
    .clkout_enable_req(req));
  gpcm_host_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid));
  task automatic chk(input string n, input gpcm_byte_t e, input gpcm_byte_t g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input gpcm_addr_t a, input gpcm_byte_t e, input string n);
    host.rd(a, d, v);
    chk({n, " valid"}, 8'h01, {7'h00, v});
    chk(n, e, d);
    @(negedge clk);
    chk({n, " valid idle"}, 8'h00, {7'h00, rd_valid});
    chk({n, " rdata idle"}, 8'h00, rdata);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    rdchk(8'h12, 8'h00, "sel reset");
    rdchk(8'h11, 8'h00, "gp reset");
    $display("test reset done");
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e, "readback");
    end
    $display("test rows done");
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h12, 8'h01 << i);
      chk("sel bits", 8'h01 << i, {4'h0, ev, al, cd, tk});
      irq = ~(4'h1 << i);
      repeat (2) @(negedge clk);
      chk("req off", 8'h00, {7'h00, req});
      irq = 4'hf;
      repeat (2) @(negedge clk);
      chk("req on", 8'h01, {7'h00, req});
    end
    host.wr(8'h12, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      irq = 4'h1 << i;
      repeat (2) @(negedge clk);
      chk("req any", 8'h01, {7'h00, req});
    end
    chk("spare kept", 8'h2a, {1'b0, spare});
    $display("test trigger done");
    write_protect = 1'b1;
    host.wr(8'h11, 8'h00);
    host.wr(8'h12, 8'h00);
    rdchk(8'h11, 8'h2a, "gp locked");
    rdchk(8'h12, 8'h0f, "sel locked");
    write_protect = 1'b0;
    host.wr(8'h20, 8'hff);
    rdchk(8'h20, 8'h00, "unmapped");
    rdchk(8'h11, 8'h2a, "spare after unmapped write");
    rdchk(8'h12, 8'h0f, "sel after unmapped write");
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    rdchk(8'h12, 8'h00, "sel rereset");
    rdchk(8'h11, 8'h00, "spare rereset");
    chk("req rereset", 8'h00, {7'h00, req});
    $display("test protect and reset done");
    end_sim();
  end
endmodule // tb
